// file: aspc_pkg.sv
// Shared constants and types of the asynchronous serial port
package aspc_pkg;
  // Bus widths
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam int BAUD_W = 13;
  // Register offsets
  localparam logic [7:0] OFF_BAUD_HI = 8'h18;
  localparam logic [7:0] OFF_BAUD_LO = 8'h19;
  localparam logic [7:0] OFF_CTRL1 = 8'h1A;
  localparam logic [7:0] OFF_STAT = 8'h1C;
  localparam logic [7:0] OFF_DATA = 8'h1D;
  localparam logic [7:0] OFF_CTRL3 = 8'h1E;
  localparam logic [7:0] OFF_ERRCLR = 8'h1F;
  // Reset values
  localparam logic [12:0] BAUD_RESET = 13'h0004;
  localparam logic [7:0] CTRL1_RESET = 8'h00;
  localparam logic [6:0] CTRL3_RESET = 7'h00;
  localparam logic [7:0] DATA_RESET = 8'h00;
  // First control register fields
  localparam int C1_TE = 7;
  localparam int C1_RE = 6;
  localparam int C1_M = 5;
  localparam int C1_PE = 4;
  localparam int C1_PT = 3;
  localparam int C1_LOOP_MODE_SELECT = 2;
  localparam int C1_RECEIVER_SOURCE_SELECT = 1;
  // Third control register fields (ninth rx bit sits on top at read)
  localparam int C3_TX9 = 6;
  localparam int C3_DIR = 5;
  localparam int C3_INV = 4;
  // Error flag layout, shared by status, enables and clear register
  localparam int ERR_OR = 3;
  localparam int ERR_NF = 2;
  localparam int ERR_FE = 1;
  localparam int ERR_PF = 0;
  // Baud prescale and oversampling
  localparam int PRESCALE = 4;
  localparam int PRE_W = 2;
  localparam logic [3:0] RT_FIRST = 4'h1;
  localparam logic [3:0] RT_LAST = 4'hF;
  localparam logic [3:0] RT_START_A = 4'h2;
  localparam logic [3:0] RT_START_B = 4'h4;
  localparam logic [3:0] RT_START_C = 4'h6;
  localparam logic [3:0] RT_SMP_A = 4'h7;
  localparam logic [3:0] RT_SMP_C = 4'h9;
  localparam logic [1:0] START_MIN_ZEROS = 2'h2;
  // Frame lengths in bit times
  localparam logic [3:0] FRAME8 = 4'hA;
  localparam logic [3:0] FRAME9 = 4'hB;
  // Transmit and receive sequencer states
  typedef enum logic [1:0] {
    ASPC_TX_IDLE = 2'h0,
    ASPC_TX_SHIFT = 2'h1
  } aspc_tx_state_t;
  typedef enum logic [1:0] {
    ASPC_RX_IDLE = 2'h0,
    ASPC_RX_START = 2'h1,
    ASPC_RX_DATA = 2'h3
  } aspc_rx_state_t;
endpackage

// file: aspc_baud_if.sv
// Link between the port core and its baud generator
`timescale 1ns/1ps
`default_nettype none
interface aspc_baud_if;
  logic [12:0] divisor;
  logic tick;
  modport gen (input divisor, output tick);
  modport user (output divisor, input tick);
endinterface
`default_nettype wire

// file: aspc_baud_gen.sv
// Shared baud generator: bus clock over four, then modulo divider
`timescale 1ns/1ps
`default_nettype none
module aspc_baud_gen (
  input wire logic sys_clk,
  input wire logic reset,
  aspc_baud_if.gen bif
);
  import aspc_pkg::*;

  typedef struct packed {
    logic [PRE_W-1:0] pre;
    logic [BAUD_W-1:0] cnt;
    logic tick;
  } aspc_baud_state_t;

  aspc_baud_state_t q;
  aspc_baud_state_t n;

  // Divide by four first, then count to the divisor
  always_comb begin
    n = q;
    n.tick = 1'b0;
    n.pre = q.pre + PRE_W'(1);
    if (q.pre == PRE_W'(PRESCALE - 1)) begin
      n.pre = '0;
      if (bif.divisor == '0) begin
        n.cnt = '0;
      end else if (q.cnt + BAUD_W'(1) >= bif.divisor) begin
        n.cnt = '0;
        n.tick = 1'b1;
      end else begin
        n.cnt = q.cnt + BAUD_W'(1);
      end
    end
  end

  // State register
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  assign bif.tick = q.tick;
endmodule
`default_nettype wire

// file: aspc_top.sv
// Serial port core: registers, transmitter, receiver, error interrupt
//
// The strobed register port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
module aspc_top (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic [aspc_pkg::ADDR_W-1:0] regAddr,
  input wire logic [aspc_pkg::DATA_W-1:0] regWrData,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [aspc_pkg::DATA_W-1:0] regRdData,
  input wire logic rxPin,
  input wire logic txPinIn,
  output logic txPinOut,
  output logic txPinOe_n,
  output logic irq
);
  import aspc_pkg::*;

  typedef struct packed {
    logic [BAUD_W-1:0] baud;
    logic [7:0] ctrl1;
    logic [6:0] ctrl3;
    logic rx9;
    logic [7:0] rxBuf;
    logic [7:0] txBuf;
    logic tx9Buf;
    logic tdre;
    logic tc;
    logic rdrf;
    logic [3:0] err;
    logic stArm;
    aspc_tx_state_t txState;
    logic [3:0] txRt;
    logic [3:0] txBit;
    logic [10:0] txShift;
    aspc_rx_state_t rxState;
    logic [3:0] rxRt;
    logic [3:0] rxBit;
    logic [8:0] rxShift;
    logic [1:0] rxZero;
    logic [2:0] rxSmp;
    logic rxNoise;
    logic rxPrev;
    logic rxS1;
    logic rxS2;
    logic twS1;
    logic twS2;
    logic txLine;
    logic txPin;
    logic [7:0] rdData;
  } aspc_state_t;

  aspc_state_t q;
  aspc_state_t n;
  aspc_baud_if bif ();

  // Two-of-three vote
  function automatic logic vote3(input logic [2:0] s);
    vote3 = (s[0] & s[1]) | (s[0] & s[2]) | (s[1] & s[2]);
  endfunction

  // Even parity of the low bits, odd when the type bit is set
  function automatic logic parityOf(input logic [8:0] v, input logic odd);
    parityOf = (^v) ^ odd;
  endfunction

  // Shared baud tick for both directions
  aspc_baud_gen baudGen (
    .sys_clk(sys_clk),
    .reset(reset),
    .bif(bif)
  );
  assign bif.divisor = q.baud;

  // Next-state logic: bus first, then hardware sets, so sets win
  always_comb begin
    logic nine;
    logic singleWire;
    logic rxSrc;
    logic fall;
    logic bitVal;
    logic [3:0] frameLen;
    logic [7:0] txData;
    logic txNinth;
    logic [2:0] smpAll;
    logic dataWrite;
    nine = q.ctrl1[C1_M];
    singleWire = q.ctrl1[C1_LOOP_MODE_SELECT] & q.ctrl1[C1_RECEIVER_SOURCE_SELECT];
    rxSrc = 1'b1;
    fall = 1'b0;
    bitVal = 1'b0;
    frameLen = nine ? FRAME9 : FRAME8;
    txData = q.txBuf;
    txNinth = q.tx9Buf;
    smpAll = 3'h0;
    dataWrite = regWrite && (regAddr == OFF_DATA);
    n = q;
    n.rxS1 = rxPin;
    n.rxS2 = q.rxS1;
    n.twS1 = txPinIn;
    n.twS2 = q.twS1;
    n.rdData = '0;

    // Register reads and their side effects
    if (regRead) begin
      case (regAddr)
        OFF_BAUD_HI: n.rdData = {3'h0, q.baud[12:8]};
        OFF_BAUD_LO: n.rdData = q.baud[7:0];
        OFF_CTRL1: n.rdData = q.ctrl1;
        OFF_STAT: begin
          n.rdData = {q.tdre, q.tc, q.rdrf, q.rxState != ASPC_RX_IDLE, q.err};
          n.stArm = q.rdrf | (|q.err);
        end
        OFF_DATA: begin
          n.rdData = q.rxBuf;
          if (q.stArm) begin
            n.rdrf = 1'b0;
            n.err = '0;
          end
          n.stArm = 1'b0;
        end
        OFF_CTRL3: n.rdData = {q.rx9, q.ctrl3};
        default: n.rdData = '0;
      endcase
    end

    // Register writes
    if (regWrite) begin
      case (regAddr)
        OFF_BAUD_HI: n.baud[12:8] = regWrData[4:0];
        OFF_BAUD_LO: n.baud[7:0] = regWrData;
        OFF_CTRL1: n.ctrl1 = regWrData;
        OFF_DATA: begin
          n.txBuf = regWrData;
          n.tx9Buf = q.ctrl3[C3_TX9];
          n.tdre = 1'b0;
          n.tc = 1'b0;
        end
        OFF_CTRL3: n.ctrl3 = regWrData[6:0];
        OFF_ERRCLR: n.err = q.err & ~regWrData[3:0];
        default: n.ctrl1 = n.ctrl1;
      endcase
    end

    // Frame contents, parity replaces the top data bit
    if (q.ctrl1[C1_PE]) begin
      if (nine) begin
        txNinth = parityOf({1'b0, q.txBuf}, q.ctrl1[C1_PT]);
      end else begin
        txData[7] = parityOf({2'h0, q.txBuf[6:0]}, q.ctrl1[C1_PT]);
      end
    end

    // Transmitter, stepped by the shared tick
    if (bif.tick) begin
      case (q.txState)
        ASPC_TX_IDLE: begin
          if (q.ctrl1[C1_TE] && !q.tdre && !dataWrite) begin
            n.txShift = {1'b1, nine ? txNinth : 1'b1, txData, 1'b0};
            n.txState = ASPC_TX_SHIFT;
            n.txRt = '0;
            n.txBit = '0;
            n.tdre = 1'b1;
          end else if (q.tdre) begin
            n.tc = 1'b1;
          end
        end
        ASPC_TX_SHIFT: begin
          n.txRt = q.txRt + 4'h1;
          if (q.txRt == RT_LAST) begin
            n.txShift = {1'b1, q.txShift[10:1]};
            n.txBit = q.txBit + 4'h1;
            if (q.txBit == frameLen - 4'h1) begin
              n.txState = ASPC_TX_IDLE;
            end
          end
        end
        default: n.txState = ASPC_TX_IDLE;
      endcase
    end
    n.txLine = (n.txState == ASPC_TX_SHIFT) ? n.txShift[0] : 1'b1;
    n.txPin = n.txLine ^ n.ctrl3[C3_INV];

    // Receive source: pin, internal loop, or shared transmit pin
    if (q.ctrl1[C1_LOOP_MODE_SELECT]) begin
      rxSrc = q.ctrl1[C1_RECEIVER_SOURCE_SELECT] ? q.twS2 : q.txLine;
    end else begin
      rxSrc = q.rxS2;
    end

    // Receiver, independent of the transmitter
    if (!q.ctrl1[C1_RE]) begin
      n.rxState = ASPC_RX_IDLE;
      n.rxPrev = 1'b1;
    end else if (bif.tick) begin
      fall = q.rxPrev & ~rxSrc;
      n.rxPrev = rxSrc;
      n.rxRt = q.rxRt + 4'h1;
      case (q.rxState)
        ASPC_RX_IDLE: begin
          if (fall) begin
            n.rxState = ASPC_RX_START;
            n.rxRt = RT_FIRST;
            n.rxZero = '0;
            n.rxNoise = 1'b0;
          end
        end
        ASPC_RX_START: begin
          if (q.rxRt == RT_START_A || q.rxRt == RT_START_B || q.rxRt == RT_START_C) begin
            n.rxZero = q.rxZero + {1'b0, ~rxSrc};
          end
          if (q.rxRt == RT_START_C && n.rxZero < START_MIN_ZEROS) begin
            n.rxState = ASPC_RX_IDLE;
          end else if (q.rxRt == RT_LAST) begin
            n.rxState = ASPC_RX_DATA;
            n.rxBit = '0;
          end
        end
        ASPC_RX_DATA: begin
          if (q.rxRt >= RT_SMP_A && q.rxRt <= RT_SMP_C) begin
            n.rxSmp = {q.rxSmp[1:0], rxSrc};
          end
          if (q.rxRt == RT_SMP_C) begin
            smpAll = {q.rxSmp[1:0], rxSrc};
            bitVal = vote3(smpAll);
            n.rxNoise = q.rxNoise | ~((&smpAll) | ~(|smpAll));
            if (q.rxBit == frameLen - 4'h2) begin
              n.rxState = ASPC_RX_IDLE;
              if (n.rdrf) begin
                n.err[ERR_OR] = 1'b1;
              end else begin
                n.rdrf = 1'b1;
                n.rxBuf = nine ? q.rxShift[7:0] : q.rxShift[8:1];
                n.rx9 = nine & q.rxShift[8];
                n.err[ERR_NF] = n.err[ERR_NF] | n.rxNoise;
                n.err[ERR_FE] = n.err[ERR_FE] | ~bitVal;
                n.err[ERR_PF] = n.err[ERR_PF] | (q.ctrl1[C1_PE]
                  & parityOf(nine ? q.rxShift : {1'b0, q.rxShift[8:1]}, q.ctrl1[C1_PT]));
              end
            end else begin
              n.rxShift = {bitVal, q.rxShift[8:1]};
            end
          end
          // Bit boundary at RT16 or early on a falling edge
          if (fall && q.rxRt > RT_SMP_C) begin
            n.rxRt = RT_FIRST;
            n.rxBit = q.rxBit + 4'h1;
          end else if (q.rxRt == RT_LAST) begin
            n.rxBit = q.rxBit + 4'h1;
          end
        end
        default: n.rxState = ASPC_RX_IDLE;
      endcase
    end
  end

  // State register with defined reset values
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      q <= '0;
      q.baud <= BAUD_RESET;
      q.ctrl1 <= CTRL1_RESET;
      q.ctrl3 <= CTRL3_RESET;
      q.rxBuf <= DATA_RESET;
      q.txBuf <= DATA_RESET;
      q.tdre <= 1'b1;
      q.tc <= 1'b1;
      q.txState <= ASPC_TX_IDLE;
      q.rxState <= ASPC_RX_IDLE;
      q.rxPrev <= 1'b1;
      q.rxS1 <= 1'b1;
      q.rxS2 <= 1'b1;
      q.twS1 <= 1'b1;
      q.twS2 <= 1'b1;
      q.txLine <= 1'b1;
      q.txPin <= 1'b1;
    end else begin
      q <= n;
    end
  end

  // Outputs
  assign regRdData = q.rdData;
  assign txPinOut = q.txPin;
  // Released only in single-wire mode with direction 0
  assign txPinOe_n = (q.ctrl1[C1_LOOP_MODE_SELECT] & q.ctrl1[C1_RECEIVER_SOURCE_SELECT]) ? ~q.ctrl3[C3_DIR] : 1'b0;
  // Level request while any enabled error flag stands
  assign irq = |(q.err & q.ctrl3[3:0]);
endmodule
`default_nettype wire

// file: aspc_monitor.sv
// Port checker for the serial port core
`timescale 1ns/1ps
`default_nettype none
module aspc_monitor (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic [aspc_pkg::ADDR_W-1:0] regAddr,
  input wire logic [aspc_pkg::DATA_W-1:0] regWrData,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [aspc_pkg::DATA_W-1:0] regRdData,
  input wire logic txPinOe_n,
  input wire logic irq
);
  import aspc_pkg::*;
  logic [7:0] ctl1_q;
  logic [7:0] ctl3_q;
  // Shadow copies of both control registers
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      ctl1_q <= 8'h00;
      ctl3_q <= 8'h00;
    end else if (regWrite && regAddr == OFF_CTRL1) begin
      ctl1_q <= regWrData;
    end else if (regWrite && regAddr == OFF_CTRL3) begin
      ctl3_q <= regWrData;
    end
  end
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (reset);
  // Status bit seen with its enable set
  property p_flag(int k);
    $past(regRead && regAddr == OFF_STAT) && regRdData[k] && ctl3_q[k] |-> irq;
  endproperty
  a_rd_idle_zero: assert property (!$past(regRead) |-> regRdData == 8'h00)
    else $error("read data outside read slot");
  a_ctl3_keeps: assert property ($past(regRead && regAddr == OFF_CTRL3) |->
    regRdData[6:0] == ctl3_q[6:0]) else $error("control three readback");
  a_pin_dir: assert property (txPinOe_n == (ctl1_q[2] & ctl1_q[1] & ~ctl3_q[5]))
    else $error("pin direction");
  a_irq_masked: assert property (ctl3_q[3:0] == 4'h0 |-> !irq)
    else $error("irq with enables clear");
  a_irq_overrun: assert property (p_flag(ERR_OR))
    else $error("overrun irq missing");
  a_irq_noise: assert property (p_flag(ERR_NF))
    else $error("noise irq missing");
  a_irq_framing: assert property (p_flag(ERR_FE))
    else $error("framing irq missing");
  a_irq_parity: assert property (p_flag(ERR_PF))
    else $error("parity irq missing");
  a_pair_clears: assert property (regRead && regAddr == OFF_STAT ##1
    regRead && regAddr == OFF_DATA |=> !irq) else $error("clear sequence");
  c_irq: cover property (irq);
  c_pin_in: cover property (txPinOe_n);
  c_data_rd: cover property (regRead && regAddr == OFF_DATA);
endmodule
bind aspc_top aspc_monitor mon (.sys_clk(sys_clk), .reset(reset), .regAddr(regAddr),
  .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead),
  .regRdData(regRdData), .txPinOe_n(txPinOe_n), .irq(irq));
`default_nettype wire

// file: aspc_remote.sv
// Remote serial device driving the receive line
`timescale 1ns/1ps
`default_nettype none
module aspc_remote (
  input wire logic sys_clk,
  output logic rxLine
);
  initial rxLine = 1'b1;
  // Start, data LSB first, stop, one idle bit
  task automatic send(input logic [8:0] val, input int n, input logic stp, input int clks);
    rxLine <= 1'b0;
    repeat (clks) @(posedge sys_clk);
    for (int i = 0; i < n; i++) begin
      rxLine <= val[i];
      repeat (clks) @(posedge sys_clk);
    end
    rxLine <= stp;
    repeat (clks) @(posedge sys_clk);
    rxLine <= 1'b1;
    repeat (clks) @(posedge sys_clk);
  endtask
endmodule
`default_nettype wire

// file: test_aspc_top.sv
// Self-checking bench for the serial port core
`timescale 1ns/1ps
`default_nettype none
module test_aspc_top;
  import aspc_pkg::*;
  logic sys_clk;
  logic reset;
  logic [7:0] regAddr;
  logic [7:0] regWrData;
  logic regWrite;
  logic regRead;
  logic [7:0] regRdData;
  logic txPinOut;
  logic txPinOe_n;
  logic irq;
  wire rxPin;
  wire txPinIn;
  int seed = 75;
  int n_fail = 0;
  int samples_checked = 0;
  logic [9:0] v;
  logic [7:0] st;
  logic [7:0] x;
  logic [7:0] d;
  logic [8:0] rv;
  logic m;
  // Single-wire pin pulled high while released
  assign txPinIn = txPinOe_n ? 1'b1 : txPinOut;
  aspc_top dut (.sys_clk(sys_clk), .reset(reset), .regAddr(regAddr),
    .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead),
    .regRdData(regRdData), .rxPin(rxPin), .txPinIn(txPinIn),
    .txPinOut(txPinOut), .txPinOe_n(txPinOe_n), .irq(irq));
  aspc_remote rem (.sys_clk(sys_clk), .rxLine(rxPin));
  // 40 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end
  task automatic check(input string what, input logic [9:0] seen, input logic [9:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD %s exp %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] dat);
    regAddr <= a;
    regWrData <= dat;
    regWrite <= 1'b1;
    @(posedge sys_clk);
    regWrite <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] q);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge sys_clk);
    regRead <= 1'b0;
    @(posedge sys_clk);
    q = regRdData;
  endtask
  // Status read then data read, back to back
  task automatic rdPair(output logic [7:0] s, output logic [7:0] q);
    regAddr <= OFF_STAT;
    regRead <= 1'b1;
    @(posedge sys_clk);
    regAddr <= OFF_DATA;
    @(posedge sys_clk);
    regRead <= 1'b0;
    s = regRdData;
    @(posedge sys_clk);
    q = regRdData;
  endtask
  // Frame from the transmit pin, sampled mid-bit
  task automatic getTx(input int n, output logic [9:0] f);
    int k;
    k = 0;
    f = 10'h000;
    while (txPinOut !== 1'b0 && k < 3000) begin
      @(posedge sys_clk);
      k++;
    end
    repeat (32) @(posedge sys_clk);
    check("start", txPinOut, 0);
    for (int i = 0; i <= n; i++) begin
      repeat (64) @(posedge sys_clk);
      f[i] = txPinOut;
    end
  endtask
  function automatic logic [9:0] expFrame(input logic [7:0] b, input logic t9, input logic w);
    expFrame = w ? {1'b1, t9, b} : {2'b01, b};
  endfunction
  task automatic close_out;
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // Main sequence
  initial begin
    reset = 1'b1;
    regAddr = 8'h00;
    regWrData = 8'h00;
    regWrite = 1'b0;
    regRead = 1'b0;
    repeat (12) @(posedge sys_clk);
    reset <= 1'b0;
    @(posedge sys_clk);
    rd(OFF_DATA, st);
    check("dataRst", st, 0);
    rd(OFF_CTRL3, st);
    check("ctl3Rst", st, 0);
    wr(8'h10, 8'hFF);
    rd(8'h10, st);
    check("unmapped", st, 0);
    wr(OFF_BAUD_HI, 8'h00);
    wr(OFF_BAUD_LO, 8'h01);
    $display("done reset");
    // Both directions at once; ninth bit held between writes
    for (int i = 0; i < 3; i++) begin
      m = (i < 2);
      wr(OFF_CTRL1, {2'b11, m, 5'h00});
      if (i != 1) wr(OFF_CTRL3, {1'b0, m, 6'h00});
      d = $random(seed);
      rv = $random(seed);
      wr(OFF_DATA, d);
      fork
        getTx(m ? 9 : 8, v);
        rem.send(rv, m ? 9 : 8, 1'b1, 63 + i);
      join
      check("txFrame", v, expFrame(d, 1'b1, m));
      rd(OFF_CTRL3, st);
      check("rxNinth", st[7], m & rv[8]);
      rdPair(st, x);
      check("status", {st[5], st[3:0]}, 10'h010);
      check("rxData", x, rv[7:0]);
    end
    $display("done duplex");
    // Second character on a full buffer
    d = $random(seed);
    rem.send({1'b0, d}, 8, 1'b1, 64);
    rem.send(9'h0A5, 8, 1'b1, 64);
    wr(OFF_CTRL3, 8'h08);
    check("irqOr", irq, 1);
    wr(OFF_CTRL3, 8'h00);
    check("irqMask", irq, 0);
    wr(OFF_CTRL3, 8'h08);
    wr(OFF_ERRCLR, 8'h0F);
    check("irqClr", irq, 0);
    rdPair(st, x);
    check("kept", x, d);
    $display("done overrun");
    // Bad stop bit, then bad even parity
    for (int e = 0; e < 2; e++) begin
      wr(OFF_CTRL1, e ? 8'hD0 : 8'hC0);
      d = $random(seed);
      d[7] = ~^d[6:0];
      rem.send({1'b0, d}, 8, e[0], 64);
      wr(OFF_CTRL3, e ? 8'h01 : 8'h02);
      check("irqErr", irq, 1);
      rdPair(st, x);
      check("errFlag", st[1 - e], 1);
      check("errData", x[6:0], d[6:0]);
      check("irqGone", irq, 0);
    end
    $display("done errors");
    // Internal loop, nine bits with odd parity carried in the ninth
    wr(OFF_CTRL1, 8'hFC);
    d = $random(seed);
    wr(OFF_DATA, d);
    repeat (800) @(posedge sys_clk);
    rd(OFF_CTRL3, st);
    check("loopNinth", st[7], ~^d);
    rdPair(st, x);
    check("loopStat", {st[5], st[3:0]}, 10'h010);
    check("loopData", x, d);
    $display("done loop");
    // Single-wire direction, then inverted idle level
    wr(OFF_CTRL1, 8'h06);
    for (int k = 0; k < 2; k++) begin
      wr(OFF_CTRL3, {2'b00, k[0], 5'h00});
      check("oeN", txPinOe_n, !k);
    end
    wr(OFF_CTRL1, 8'h00);
    wr(OFF_CTRL3, 8'h10);
    @(posedge sys_clk);
    check("idleInv", txPinOut, 0);
    wr(OFF_CTRL3, 8'h00);
    @(posedge sys_clk);
    check("idle", txPinOut, 1);
    $display("done pins");
    close_out;
  end
  // Cuts a hung run short
  initial begin
    repeat (40000) @(posedge sys_clk);
    n_fail++;
    close_out;
  end
endmodule
`default_nettype wire
